// ==== common/bcl_defines.svh ====
// Offsets, field positions, reset values and timing counts of the cipher load port
`ifndef BCL_DEFINES_SVH
`define BCL_DEFINES_SVH

// Engine register map on the byte bus
`define BCL_OFF_DATA 12'hfb8
`define BCL_OFF_KEY 12'hfb9
`define BCL_OFF_CTRL 12'hfba
`define BCL_OFF_STAT 12'hfbb

// Engine control fields
`define BCL_CTL_EN 0
`define BCL_CTL_DECRYPT 1
`define BCL_CTL_VSEL 2
`define BCL_CTL_MODE_LO 3
`define BCL_CTL_MODE_HI 4
`define BCL_CTL_IRQ 5
`define BCL_CTL_AUTODIS 7
`define BCL_CTL_WMASK 8'hbf
`define BCL_CTL_RESET 8'h00

// Engine status fields
`define BCL_ST_LOADED_DATA 0
`define BCL_ST_LOADED_KEY 1
`define BCL_ST_LOADED_VEC 2
`define BCL_ST_ERROR 3
`define BCL_ST_BUSY 7

// Modes that consume the chaining vector
`define BCL_MODE_OFB 2'b01
`define BCL_MODE_CBC 2'b10

// Load length and stand-in operation length
`define BCL_BLOCK_BYTES 16
`define BCL_OP_CYCLES 12

// Controller register map on Avalon-MM, byte addresses
`define BCL_H_OFF_ADDR 5'h00
`define BCL_H_OFF_WDATA 5'h04
`define BCL_H_OFF_CMD 5'h08
`define BCL_H_OFF_RDATA 5'h0c
`define BCL_H_OFF_IRQ_STAT 5'h10
`define BCL_H_OFF_IRQ_MASK 5'h14
`define BCL_H_OFF_STATE 5'h18
`define BCL_H_CMD_WRITE 0
`define BCL_H_CMD_READ 1
`define BCL_H_EV_DONE 0
`define BCL_H_EV_ERROR 1

`endif

// ==== common/bcl_pkg.sv ====
// Types shared by both ends of the cipher load port
package bcl_pkg;
    typedef logic [7:0] bcl_byte_t;
    typedef logic [127:0] bcl_block_t;

    typedef enum logic [1:0] {
        BCL_H_IDLE = 2'b00,
        BCL_H_RDWAIT = 2'b01
    } bcl_host_state_t;

    function automatic logic bcl_uses_vector(input logic [1:0] mode);
        return (mode == 2'b01) || (mode == 2'b10);
    endfunction : bcl_uses_vector
endpackage : bcl_pkg

// ==== common/bcl_bus_if.sv ====
// Byte-wide register bus between the controller and the engine port
interface bcl_bus_if;
    logic [11:0] addr;
    logic wr_en;
    logic rd_en;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;

    modport dev (
        input addr,
        input wr_en,
        input rd_en,
        input wdata,
        output rdata,
        output rvalid
    );

    modport host (
        output addr,
        output wr_en,
        output rd_en,
        output wdata,
        input rdata,
        input rvalid
    );
endinterface : bcl_bus_if

// ==== verilog/bcl_byte_loader.sv ====
// Byte-serial loader that assembles a block, first byte into the top byte
`include "bcl_defines.svh"
module bcl_byte_loader #(
    parameter int BYTES = `BCL_BLOCK_BYTES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic load,
    input wire logic [7:0] byte_in,
    output logic [8*BYTES-1:0] block_out,
    output logic last
);
    localparam int CNTW = $clog2(BYTES);
    localparam logic [CNTW-1:0] CNT_LAST = CNTW'(BYTES - 1);

    logic [CNTW-1:0] cnt_reg;

    assign last = load && (cnt_reg == CNT_LAST);

    always_ff @(posedge ref_clk) begin
        if (sys_rst || clear) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= last ? '0 : cnt_reg + 1'b1;
        end
    end

    // Shifting left leaves the first byte on top after a full load
    always_ff @(posedge ref_clk) begin
        if (sys_rst || clear) begin
            block_out <= '0;
        end else if (load) begin
            block_out <= {block_out[8*BYTES-9:0], byte_in};
        end
    end
endmodule : bcl_byte_loader

// ==== verilog/bcl_engine_port.sv ====
// Register front end of the block cipher engine: key, vector and data load ports
//
// The Avalon-MM interface to the registers was left to the implementer.
`include "bcl_defines.svh"
// Notes on behaviour
// - Shared address routed by vector-select bit
// - Data port: writes input, reads result
// - Sixteen data bytes set data-loaded flag
// - Software loads key and vector before data
// - Data or vector write while busy: error
// - Vector used only in feedback, chaining modes
// - Sixteen vector bytes set vector-loaded flag
// - Sixteen key bytes set key-loaded flag
// - Finish key load before data load
// - Key write while busy: dropped, error set
// - Disable clears key; reload after enable
// - Vector select at control bit two
// - Writing go starts; busy until done
// - Status bits three..zero; reset on disable
module bcl_engine_port
    import bcl_pkg::*;
#(
    parameter int OP_CYCLES = `BCL_OP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    bcl_bus_if.dev bus,
    output logic op_busy,
    output logic op_done
);
    localparam int CW = $clog2(OP_CYCLES + 1);
    localparam logic [CW-1:0] OP_LAST = CW'(OP_CYCLES - 1);

    logic [7:0] ctrl_reg;
    logic busy_reg;
    logic err_reg;
    logic vld_reg;
    logic kld_reg;
    logic dld_reg;
    logic done_reg;
    logic [CW-1:0] op_cnt_reg;
    bcl_block_t res_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;

    logic en;
    logic vsel;
    logic [1:0] mode;
    logic hit_shared;
    logic hit_key;
    logic hit_ctrl;
    logic hit_stat;
    logic port_wr;
    logic wr_ok;
    logic acc_d;
    logic acc_v;
    logic acc_k;
    logic err_set;
    logic vec_ok;
    logic sw_start;
    logic auto_start;
    logic start;
    logic finish;
    logic rd_result;
    logic d_last;
    logic v_last;
    logic k_last;
    bcl_block_t key_blk;
    bcl_block_t vec_blk;
    bcl_block_t dat_blk;
    bcl_block_t chain_term;

    assign en = ctrl_reg[`BCL_CTL_EN];
    assign vsel = ctrl_reg[`BCL_CTL_VSEL];
    assign mode = ctrl_reg[`BCL_CTL_MODE_HI:`BCL_CTL_MODE_LO];

    assign hit_shared = (bus.addr == `BCL_OFF_DATA);
    assign hit_key = (bus.addr == `BCL_OFF_KEY);
    assign hit_ctrl = (bus.addr == `BCL_OFF_CTRL);
    assign hit_stat = (bus.addr == `BCL_OFF_STAT);

    // Writes to the load ports while disabled are dropped silently: the
    // loaders are held clear then, so nothing could be kept anyway
    assign port_wr = bus.wr_en && (hit_shared || hit_key);
    assign wr_ok = port_wr && en && !busy_reg;
    assign acc_d = wr_ok && hit_shared && !vsel;
    assign acc_v = wr_ok && hit_shared && vsel;
    assign acc_k = wr_ok && hit_key;
    assign err_set = port_wr && en && busy_reg;

    assign vec_ok = !bcl_uses_vector(mode) || vld_reg;
    assign sw_start = bus.wr_en && hit_stat && bus.wdata[`BCL_ST_BUSY]
        && en && !busy_reg;
    // Auto-start waits for every load it needs and for vector select to drop
    assign auto_start = !ctrl_reg[`BCL_CTL_AUTODIS] && en && !busy_reg && !vsel
        && dld_reg && kld_reg && vec_ok;
    assign start = sw_start || auto_start;
    assign finish = busy_reg && (op_cnt_reg == OP_LAST);

    assign rd_result = bus.rd_en && hit_shared && !vsel;
    assign chain_term = bcl_uses_vector(mode) ? vec_blk : '0;

    // Disabling the engine wipes the key, vector and all byte counters
    bcl_byte_loader #(
        .BYTES(`BCL_BLOCK_BYTES)
    ) u_key_loader (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(!en),
        .load(acc_k),
        .byte_in(bus.wdata),
        .block_out(key_blk),
        .last(k_last)
    );

    bcl_byte_loader #(
        .BYTES(`BCL_BLOCK_BYTES)
    ) u_vec_loader (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(!en),
        .load(acc_v),
        .byte_in(bus.wdata),
        .block_out(vec_blk),
        .last(v_last)
    );

    bcl_byte_loader #(
        .BYTES(`BCL_BLOCK_BYTES)
    ) u_dat_loader (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(!en),
        .load(acc_d),
        .byte_in(bus.wdata),
        .block_out(dat_blk),
        .last(d_last)
    );

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl_reg <= `BCL_CTL_RESET;
        end else if (bus.wr_en && hit_ctrl) begin
            ctrl_reg <= bus.wdata & `BCL_CTL_WMASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !en) begin
            busy_reg <= 1'b0;
        end else if (start) begin
            busy_reg <= 1'b1;
        end else if (finish) begin
            busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !busy_reg) begin
            op_cnt_reg <= '0;
        end else begin
            op_cnt_reg <= op_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= finish;
        end
    end

    // Stand-in for the cipher rounds: the result mixes block, key and, in OFB and CBC modes only, vector.
    // Reads rotate the result so sixteen reads return it top byte first.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res_reg <= '0;
        end else if (finish) begin
            res_reg <= dat_blk ^ key_blk ^ chain_term;
        end else if (rd_result) begin
            res_reg <= {res_reg[119:0], res_reg[127:120]};
        end
    end

    // Loaded flags: the completing byte wins over any clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !en) begin
            dld_reg <= 1'b0;
        end else begin
            if (start) begin
                dld_reg <= 1'b0;
            end
            if (d_last) begin
                dld_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !en) begin
            kld_reg <= 1'b0;
        end else begin
            if (acc_k) begin
                kld_reg <= 1'b0;
            end
            if (k_last) begin
                kld_reg <= 1'b1;
            end
        end
    end

    // A single vector byte drops the flag until the next full load
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !en) begin
            vld_reg <= 1'b0;
        end else begin
            if (acc_v) begin
                vld_reg <= 1'b0;
            end
            if (v_last) begin
                vld_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !en) begin
            err_reg <= 1'b0;
        end else if (err_set) begin
            err_reg <= 1'b1;
        end
    end

    // Key and vector read as zero; reserved status bits read as zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (bus.rd_en) begin
            if (rd_result) begin
                rdata_reg <= res_reg[127:120];
            end else if (hit_ctrl) begin
                rdata_reg <= ctrl_reg;
            end else if (hit_stat) begin
                rdata_reg <= {busy_reg, 3'h0, err_reg, vld_reg, kld_reg, dld_reg};
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= bus.rd_en;
        end
    end

    assign bus.rdata = rdata_reg;
    assign bus.rvalid = rvalid_reg;
    assign op_busy = busy_reg;
    assign op_done = done_reg;
endmodule : bcl_engine_port

// ==== verilog/bcl_host_ctrl.sv ====
// Controller end: Avalon-MM registers turned into byte bus accesses
`include "bcl_defines.svh"
module bcl_host_ctrl
    import bcl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    bcl_bus_if.host bus
);
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction : be_merge

    bcl_host_state_t state_reg;
    logic [11:0] addr_reg;
    logic [7:0] wdat_reg;
    logic [7:0] rdat_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic wr_en_reg;
    logic rd_en_reg;
    logic rd_ack_reg;
    logic [31:0] readdata_reg;

    logic host_busy;
    logic wr_take;
    logic rd_take;
    logic cmd_hit;
    logic go_write;
    logic go_read;
    logic rd_back;
    logic [1:0] events;
    logic [31:0] rd_mux;
    logic [31:0] addr_mrg;
    logic [31:0] wdat_mrg;
    logic [31:0] mask_mrg;

    assign addr_mrg = be_merge({20'h00000, addr_reg}, avs_writedata, avs_byteenable);
    assign wdat_mrg = be_merge({24'h000000, wdat_reg}, avs_writedata, avs_byteenable);
    assign mask_mrg = be_merge({30'h0, irq_mask_reg}, avs_writedata, avs_byteenable);

    assign host_busy = (state_reg != BCL_H_IDLE) || wr_en_reg;
    assign cmd_hit = (avs_address == `BCL_H_OFF_CMD);
    // Reads take two cycles so read data comes from a flip-flop
    assign avs_waitrequest = (avs_read && !rd_ack_reg) || (avs_write && cmd_hit && host_busy);
    assign wr_take = avs_write && !avs_waitrequest;
    assign rd_take = avs_read && !avs_waitrequest;
    assign go_write = wr_take && cmd_hit && avs_byteenable[0]
        && avs_writedata[`BCL_H_CMD_WRITE];
    assign go_read = wr_take && cmd_hit && avs_byteenable[0] && !go_write
        && avs_writedata[`BCL_H_CMD_READ];
    assign rd_back = (state_reg == BCL_H_RDWAIT) && bus.rvalid;
    assign events[`BCL_H_EV_DONE] = wr_en_reg || rd_back;
    assign events[`BCL_H_EV_ERROR] = rd_back && (addr_reg == `BCL_OFF_STAT)
        && bus.rdata[`BCL_ST_ERROR];

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `BCL_H_OFF_ADDR: rd_mux = {20'h00000, addr_reg};
            `BCL_H_OFF_WDATA: rd_mux = {24'h000000, wdat_reg};
            `BCL_H_OFF_RDATA: rd_mux = {24'h000000, rdat_reg};
            `BCL_H_OFF_IRQ_STAT: rd_mux = {30'h0, irq_stat_reg};
            `BCL_H_OFF_IRQ_MASK: rd_mux = {30'h0, irq_mask_reg};
            `BCL_H_OFF_STATE: rd_mux = {31'h0, host_busy};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_ack_reg <= 1'b0;
            readdata_reg <= 32'h0000_0000;
        end else begin
            rd_ack_reg <= avs_read && !rd_ack_reg;
            if (avs_read && !rd_ack_reg) begin
                readdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            addr_reg <= 12'h000;
            wdat_reg <= 8'h00;
            irq_mask_reg <= 2'h0;
        end else if (wr_take) begin
            if (avs_address == `BCL_H_OFF_ADDR) begin
                addr_reg <= addr_mrg[11:0];
            end
            if (avs_address == `BCL_H_OFF_WDATA) begin
                wdat_reg <= wdat_mrg[7:0];
            end
            if (avs_address == `BCL_H_OFF_IRQ_MASK) begin
                irq_mask_reg <= mask_mrg[1:0];
            end
        end
    end

    // Read-to-clear of only the bits the read returned: an event that lands
    // between capture and completion of the read is kept for the next read
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_stat_reg <= 2'h0;
        end else if (rd_take && avs_address == `BCL_H_OFF_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~readdata_reg[1:0]) | events;
        end else begin
            irq_stat_reg <= irq_stat_reg | events;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= BCL_H_IDLE;
            wr_en_reg <= 1'b0;
            rd_en_reg <= 1'b0;
            rdat_reg <= 8'h00;
        end else begin
            wr_en_reg <= go_write;
            rd_en_reg <= go_read;
            case (state_reg)
                BCL_H_IDLE: begin
                    if (go_read) begin
                        state_reg <= BCL_H_RDWAIT;
                    end
                end
                BCL_H_RDWAIT: begin
                    if (bus.rvalid) begin
                        rdat_reg <= bus.rdata;
                        state_reg <= BCL_H_IDLE;
                    end
                end
                default: state_reg <= BCL_H_IDLE;
            endcase
        end
    end

    // Load order and key reload after enable stay with the software driving us
    assign bus.addr = addr_reg;
    assign bus.wdata = wdat_reg;
    assign bus.wr_en = wr_en_reg;
    assign bus.rd_en = rd_en_reg;
    assign avs_readdata = readdata_reg;
    assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule : bcl_host_ctrl

// ==== sim/bcl_bus_asserts.sv ====
// Assertions on the byte bus between the controller and the engine port
`include "bcl_defines.svh"
module bcl_bus_asserts #(
    parameter int OP_CYCLES = `BCL_OP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [11:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic op_busy,
    input wire logic op_done
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BUSY_LAST = OP_CYCLES - 1;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    property p_rd_answer;
        rd_en |=> rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered in the next cycle");
    property p_no_stray;
        rvalid |-> $past(rd_en);
    endproperty
    a_no_stray: assert property (p_no_stray)
        else $error("read answer without a read");
    property p_rdata_hold;
        !rvalid |-> $stable(rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read byte changed outside an answer");
    property p_key_zero;
        rd_en && addr == `BCL_OFF_KEY |=> rdata == 8'h00;
    endproperty
    a_key_zero: assert property (p_key_zero)
        else $error("key port read back nonzero");
    property p_busy_len;
        $rose(op_busy) |-> ##BUSY_LAST op_busy ##1 !op_busy;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    property p_done;
        op_done |-> !op_busy && ($past(op_busy) || $past(op_busy, 2)) ##1 !op_done;
    endproperty
    a_done: assert property (p_done)
        else $error("done pulse not tied to end of busy");
    property p_stat_busy;
        rd_en && addr == `BCL_OFF_STAT |=> rdata[7] == $past(op_busy);
    endproperty
    a_stat_busy: assert property (p_stat_busy)
        else $error("status busy bit differs from busy output");
    property p_stat_rsvd;
        rd_en && addr == `BCL_OFF_STAT |=> rdata[6:4] == 3'h0;
    endproperty
    a_stat_rsvd: assert property (p_stat_rsvd)
        else $error("reserved status bits set");
    property p_ctl_rsvd;
        rd_en && addr == `BCL_OFF_CTRL |=> !rdata[6];
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd)
        else $error("reserved control bit set");
    property p_wr_pulse;
        wr_en |=> !wr_en;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("byte write longer than one cycle");
endmodule : bcl_bus_asserts

// ==== sim/tb.sv ====
// Bench: controller and engine port joined over the byte bus, driven over Avalon-MM
`include "bcl_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OPC = 60;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic op_busy;
    logic op_done;
    logic [31:0] r;
    int n_mismatch = 0;
    int total_checks = 0;

    always #2 ref_clk = ~ref_clk;

    bcl_bus_if bus ();
    bcl_engine_port #(.OP_CYCLES(OPC)) i_bcl_engine_port (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus), .op_busy(op_busy), .op_done(op_done));
    bcl_host_ctrl i_bcl_host_ctrl (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .bus(bus));
    bcl_bus_asserts #(.OP_CYCLES(OPC)) i_bcl_bus_asserts (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(bus.addr), .wr_en(bus.wr_en),
        .rd_en(bus.rd_en), .rdata(bus.rdata), .rvalid(bus.rvalid), .op_busy(op_busy),
        .op_done(op_done));

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Waitrequest and read data are taken at the edge that completes the transfer
    task automatic av_xfer(input logic [4:0] a, input logic wr, input logic [31:0] wd,
                           output logic [31:0] rd);
        logic ws;
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        do begin
            @(posedge ref_clk);
            ws = avs_waitrequest;
            rd = avs_readdata;
            n++;
        end while (ws !== 1'b0 && n < 100);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
        if (ws !== 1'b0) begin
            n_mismatch++;
            close_out();
        end
    endtask : av_xfer

    task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        av_xfer(a, 1'b1, d, x);
    endtask : av_wr

    task automatic av_rd(input logic [4:0] a, output logic [31:0] d);
        av_xfer(a, 1'b0, 32'h0, d);
    endtask : av_rd

    task automatic eng_wr(input logic [11:0] a, input logic [7:0] d);
        av_wr(`BCL_H_OFF_ADDR, {20'h0, a});
        av_wr(`BCL_H_OFF_WDATA, {24'h0, d});
        av_wr(`BCL_H_OFF_CMD, 32'h1);
    endtask : eng_wr

    task automatic eng_rd(input logic [11:0] a, output logic [7:0] d);
        logic [31:0] s;
        int n;
        av_wr(`BCL_H_OFF_ADDR, {20'h0, a});
        av_wr(`BCL_H_OFF_CMD, 32'h2);
        n = 0;
        s = 32'h1;
        while (s[0] !== 1'b0 && n < 20) begin
            av_rd(`BCL_H_OFF_STATE, s);
            n++;
        end
        if (s[0] !== 1'b0) begin
            n_mismatch++;
            close_out();
        end
        av_rd(`BCL_H_OFF_RDATA, s);
        d = s[7:0];
    endtask : eng_rd

    task automatic eng_chk(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] b;
        eng_rd(a, b);
        chk({24'h0, b}, {24'h0, e});
    endtask : eng_chk

    task automatic ld(input logic [11:0] a, input logic [7:0] base);
        for (int i = 0; i < 16; i++) begin
            eng_wr(a, base + 8'(i));
        end
    endtask : ld

    // Loads a block, starts it unless autostart is expected, then reads the result back
    task automatic run_block(input logic [7:0] db, kb, vb, input logic ko, vo, go, hit);
        logic [7:0] b;
        logic [7:0] e;
        int n;
        ld(`BCL_OFF_DATA, db);
        if (hit) begin
            eng_chk(`BCL_OFF_STAT, 8'h07);
        end
        if (go) begin
            eng_wr(`BCL_OFF_STAT, 8'h80);
        end
        if (hit) begin
            eng_chk(`BCL_OFF_STAT, 8'h86);
            eng_wr(`BCL_OFF_DATA, 8'hee);
            eng_wr(`BCL_OFF_KEY, 8'hee);
            eng_chk(`BCL_OFF_STAT, 8'h8e);
        end
        n = 0;
        b = 8'h80;
        while (b[7] !== 1'b0 && n < 40) begin
            eng_rd(`BCL_OFF_STAT, b);
            n++;
        end
        if (b[7] !== 1'b0) begin
            n_mismatch++;
            close_out();
        end
        for (int i = 0; i < 16; i++) begin
            eng_rd(`BCL_OFF_DATA, b);
            e = (db + 8'(i)) ^ ((kb + 8'(i)) & {8{ko}}) ^ ((vb + 8'(i)) & {8{vo}});
            chk({24'h0, b}, {24'h0, e});
        end
    endtask : run_block

    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        eng_chk(`BCL_OFF_CTRL, 8'h00);
        eng_chk(`BCL_OFF_STAT, 8'h00);
        eng_chk(`BCL_OFF_KEY, 8'h00);
        av_rd(5'h1c, r);
        chk(r, 32'h0);
        av_wr(`BCL_H_OFF_IRQ_MASK, 32'h0);
        av_rd(`BCL_H_OFF_IRQ_STAT, r);
        eng_wr(`BCL_OFF_CTRL, 8'hff);
        eng_chk(`BCL_OFF_CTRL, 8'hbf);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        av_wr(`BCL_H_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        av_rd(`BCL_H_OFF_IRQ_STAT, r);
        chk(r, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, 32'h0);
        eng_wr(`BCL_OFF_CTRL, 8'h81);
        for (int i = 0; i < 15; i++) begin
            eng_wr(`BCL_OFF_KEY, 8'h30 + 8'(i));
        end
        eng_chk(`BCL_OFF_STAT, 8'h00);
        eng_wr(`BCL_OFF_KEY, 8'h3f);
        eng_chk(`BCL_OFF_STAT, 8'h02);
        eng_wr(`BCL_OFF_CTRL, 8'h95);
        ld(`BCL_OFF_DATA, 8'h5a);
        eng_chk(`BCL_OFF_STAT, 8'h06);
        eng_chk(`BCL_OFF_DATA, 8'h00);
        eng_wr(`BCL_OFF_CTRL, 8'h91);
        run_block(8'ha0, 8'h30, 8'h5a, 1'b1, 1'b1, 1'b1, 1'b1);
        for (int m = 0; m < 4; m++) begin
            eng_wr(`BCL_OFF_CTRL, 8'h81 | 8'(m << 3));
            run_block(8'hc0 + 8'(m * 16), 8'h30, 8'h5a, 1'b1, m == 1 || m == 2, 1'b1, 1'b0);
        end
        // Disable wipes key and flags; the next block runs with an all-zero key
        eng_wr(`BCL_OFF_CTRL, 8'h00);
        eng_chk(`BCL_OFF_STAT, 8'h00);
        eng_wr(`BCL_OFF_CTRL, 8'h01);
        eng_chk(`BCL_OFF_STAT, 8'h00);
        run_block(8'h11, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
        ld(`BCL_OFF_KEY, 8'h30);
        run_block(8'h22, 8'h30, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
        av_rd(`BCL_H_OFF_IRQ_STAT, r);
        chk(r, 32'h3);
        close_out();
    end
endmodule : tb
